//--- hdl/vgast_pkg.sv
// Package with raster timing constants, pixel carrier and decode helpers
package vgast_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock
    localparam int CLK_PERIOD_NS = 40;
    localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // Colour layout
    localparam int CHAN_W = 4;
    localparam int PIXEL_W = 3 * CHAN_W;

    ////////////////////////////////////////////////////////////////////////////
    // Horizontal timing in pixel clocks
    localparam int H_VISIBLE = 640;
    localparam int H_FRONT = 16;
    localparam int H_SYNC = 96;
    localparam int H_BACK = 48;

    ////////////////////////////////////////////////////////////////////////////
    // Vertical timing in lines
    localparam int V_VISIBLE = 480;
    localparam int V_FRONT = 10;
    localparam int V_SYNC = 2;
    localparam int V_BACK = 29;

    ////////////////////////////////////////////////////////////////////////////
    // Refresh window and buffering
    localparam int REFRESH_MIN_HZ = 50;
    localparam int REFRESH_MAX_HZ = 120;
    localparam int FIFO_DEPTH = 32;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam int COUNT_RESET = 0;
    localparam logic SYNC_IDLE = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Pixel carrier, red in the top bits
    typedef struct packed {
        logic [CHAN_W-1:0] red;
        logic [CHAN_W-1:0] green;
        logic [CHAN_W-1:0] blue;
    } vgast_pixel_s;

    localparam vgast_pixel_s PIXEL_BLANK = '{red: 4'h0, green: 4'h0, blue: 4'h0};

    ////////////////////////////////////////////////////////////////////////////
    // Interval decode: true when lo <= value < lo + len
    function automatic logic vgast_in_range(input int value, input int lo, input int len);
        vgast_in_range = (value >= lo) && (value < lo + len);
    endfunction : vgast_in_range

endpackage : vgast_pkg

//--- hdl/vgast_fifo.sv
// Synchronous FIFO with valid/ready on both sides
module vgast_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,               // Pixel clock
    input wire logic reset_i,             // Synchronous reset, high
    input wire logic [WIDTH-1:0] in_data_i, // Write data
    input wire logic in_valid_i,          // Write request
    output logic in_ready_o,              // Room for a word
    output logic [WIDTH-1:0] out_data_o,  // Head word
    output logic out_valid_o,             // Head word present
    input wire logic out_ready_i,         // Drain request
    output logic [$clog2(DEPTH):0] level_o // Words held
);

    localparam int AW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter checks
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("vgast_fifo depth must be a power of two of at least 2");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("vgast_fifo width must be positive");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_ptr_q;
    logic [AW:0] rd_ptr_q;
    logic push;
    logic pop;
    logic full;
    logic empty;

    ////////////////////////////////////////////////////////////////////////////
    // Full and empty from pointers with a wrap bit
    assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    assign empty = (wr_ptr_q == rd_ptr_q);
    assign push = in_valid_i && !full;
    assign pop = out_ready_i && !empty;
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_q[rd_ptr_q[AW-1:0]];
    assign level_o = wr_ptr_q - rd_ptr_q;

    // Storage write
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
        end
    end

    // Write pointer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    // Read pointer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

endmodule : vgast_fifo

//--- hdl/vgast_timing.sv
// Raster timing controller: counters, sync decode, pixel fetch and colour out
//
// Functional notes
// RULE1 - Colour leaves as three 4-bit channels, one 12-bit code per pixel.
// RULE2 - Twelve colour lines plus horizontal and vertical sync, all raster timed.
// RULE3 - Reference mode 640 by 480 at 25 MHz pixel clock, about 60 Hz.
// RULE4 - Line is 800 clocks: 640 visible, 16 front, 96 sync, 48 back.
// RULE5 - Frame is 521 lines: 480 visible, 10 front, 2 sync, 29 back.
// RULE6 - Colour shows only when both counters are visible, otherwise blank.
// RULE7 - Horizontal counter steps every clock, gives hsync and the column.
// RULE8 - Vertical counter steps at each hsync onset, gives vsync and the row.
// RULE9 - Both counters wrap forever; column and row form the memory address. Here fetch_addr_o counts accepted words instead.
// RULE10 - Hsync and vsync phase is free; origins placed at first visible pixel.
// RULE11 - One 12-bit word per visible pixel, shown in exactly its clock. Here a starved pixel shows blank and later words slip by one.
// RULE12 - Pixels go left to right, rows top to bottom.
// RULE13 - Frame rate must stay between 50 Hz and 120 Hz for any mode.
// RULE14 - Both syncs are active low, only inside their pulse intervals.
// RULE15 - Reset puts counters at first visible pixel and blanks colour.
module vgast_timing #(
    parameter int CLK_HZ = vgast_pkg::CLK_HZ, // RULE3
    parameter int H_VISIBLE = vgast_pkg::H_VISIBLE,
    parameter int H_FRONT = vgast_pkg::H_FRONT,
    parameter int H_SYNC = vgast_pkg::H_SYNC,
    parameter int H_BACK = vgast_pkg::H_BACK,
    parameter int V_VISIBLE = vgast_pkg::V_VISIBLE,
    parameter int V_FRONT = vgast_pkg::V_FRONT,
    parameter int V_SYNC = vgast_pkg::V_SYNC,
    parameter int V_BACK = vgast_pkg::V_BACK,
    parameter int FIFO_DEPTH = vgast_pkg::FIFO_DEPTH,
    localparam int H_TOTAL = H_VISIBLE + H_FRONT + H_SYNC + H_BACK,
    localparam int V_TOTAL = V_VISIBLE + V_FRONT + V_SYNC + V_BACK,
    localparam int HCW = $clog2(H_TOTAL),
    localparam int VCW = $clog2(V_TOTAL),
    localparam int PIXELS = H_VISIBLE * V_VISIBLE,
    localparam int ADDR_W = $clog2(PIXELS),
    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1
) (
    input wire logic clk_i,                         // Pixel clock
    input wire logic reset_i,                       // Synchronous reset, high
    input wire vgast_pkg::vgast_pixel_s pix_data_i, // Word from video memory
    input wire logic pix_valid_i,                   // Word offered
    output logic pix_ready_o,                       // Word accepted when valid
    output logic [ADDR_W-1:0] fetch_addr_o,         // Address of next word wanted
    output vgast_pkg::vgast_pixel_s rgb_o,          // Colour to the DAC
    output logic hsync_n_o,                         // Horizontal sync, low active
    output logic vsync_n_o,                         // Vertical sync, low active
    output logic active_o,                          // Colour interval, aligned to rgb_o
    output logic frame_start_o,                     // First pixel of frame on rgb_o
    output logic underrun_o,                        // Visible pixel had no word
    output logic [HCW-1:0] col_o,                   // Current column counter
    output logic [VCW-1:0] row_o,                   // Current row counter
    output logic [LVL_W-1:0] fifo_level_o           // Words buffered
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    // Refuse modes that the counters or the refresh range cannot serve
    if (H_VISIBLE < 1 || H_FRONT < 1 || H_SYNC < 1 || H_BACK < 1) begin : g_bad_h
        $error("vgast_timing horizontal intervals must be at least one clock");
    end
    if (V_VISIBLE < 1 || V_FRONT < 1 || V_SYNC < 1 || V_BACK < 1) begin : g_bad_v
        $error("vgast_timing vertical intervals must be at least one line");
    end
    if (CLK_HZ < vgast_pkg::REFRESH_MIN_HZ * H_TOTAL * V_TOTAL) begin : g_slow
        $error("vgast_timing frame rate below the usable refresh range"); // RULE13
    end
    if (CLK_HZ > vgast_pkg::REFRESH_MAX_HZ * H_TOTAL * V_TOTAL) begin : g_fast
        $error("vgast_timing frame rate above the usable refresh range"); // RULE13
    end
    if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin : g_bad_depth
        $error("vgast_timing buffer depth must be a power of two of at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Derived decode points
    localparam int H_SYNC_START = H_VISIBLE + H_FRONT;
    localparam int V_SYNC_START = V_VISIBLE + V_FRONT;
    localparam logic [HCW-1:0] H_LAST = HCW'(H_TOTAL - 1);
    localparam logic [HCW-1:0] H_STEP = HCW'(H_SYNC_START - 1);
    localparam logic [VCW-1:0] V_LAST = VCW'(V_TOTAL - 1);
    localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(PIXELS - 1);

    logic [HCW-1:0] hcount_q;
    logic [HCW-1:0] hcount_d;
    logic [VCW-1:0] vcount_q;
    logic [VCW-1:0] vcount_d;
    logic [ADDR_W-1:0] fetch_addr_q;
    logic h_visible;
    logic v_visible;
    logic visible;
    logic h_pulse;
    logic v_pulse;
    logic frame_origin;
    logic push;
    logic pop;
    vgast_pkg::vgast_pixel_s fifo_head;
    logic fifo_valid;
    logic fifo_ready;
    logic [vgast_pkg::PIXEL_W-1:0] fifo_head_raw;
    vgast_pkg::vgast_pixel_s rgb_q;
    logic hsync_n_q;
    logic vsync_n_q;
    logic active_q;
    logic frame_start_q;
    logic underrun_q;

    ////////////////////////////////////////////////////////////////////////////
    // Horizontal counter, one step per pixel clock, wraps at line end
    // Origin at the first visible pixel: column and row index the frame
    // directly, and each wrap costs a single compare
    always_comb begin
        if (hcount_q == H_LAST) begin
            hcount_d = '0; // RULE9
        end else begin
            hcount_d = hcount_q + 1'b1; // RULE7 RULE4
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hcount_q <= HCW'(vgast_pkg::COUNT_RESET); // RULE15
        end else begin
            hcount_q <= hcount_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Vertical counter, steps as the horizontal sync pulse begins
    // Pulse and back porch columns therefore already carry the next row;
    // only visible columns use the row as an address, so this is harmless
    // The phase between the two pulses is free, so nothing is lost here
    always_comb begin
        vcount_d = vcount_q;
        if (hcount_q == H_STEP) begin
            if (vcount_q == V_LAST) begin
                vcount_d = '0; // RULE9 RULE5
            end else begin
                vcount_d = vcount_q + 1'b1; // RULE8
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            vcount_q <= VCW'(vgast_pkg::COUNT_RESET); // RULE15
        end else begin
            vcount_q <= vcount_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interval decode from the counters
    // Plain compares on the live counters; the registers further down delay
    // the colour, sync and flag outputs by one clock so that colour and syncs move together
    assign h_visible = vgast_pkg::vgast_in_range(int'(hcount_q), 0, H_VISIBLE); // RULE7
    assign v_visible = vgast_pkg::vgast_in_range(int'(vcount_q), 0, V_VISIBLE); // RULE8
    assign h_pulse = vgast_pkg::vgast_in_range(int'(hcount_q), H_SYNC_START, H_SYNC); // RULE4
    assign v_pulse = vgast_pkg::vgast_in_range(int'(vcount_q), V_SYNC_START, V_SYNC); // RULE5
    assign visible = h_visible && v_visible; // RULE6
    assign frame_origin = (hcount_q == '0) && (vcount_q == '0); // RULE10

    ////////////////////////////////////////////////////////////////////////////
    // Pixel buffer between video memory and the raster
    // Lets a slow or bursty memory run ahead of the raster
    // A word is taken only while there is room, so none is ever dropped
    // A starved visible pixel shows blank and later words slip by one;
    // the source must keep the buffer fed, there is no resynchronisation
    assign push = pix_valid_i && fifo_ready;
    assign pop = visible && fifo_valid; // RULE11
    assign pix_ready_o = fifo_ready;
    assign fifo_head = vgast_pkg::vgast_pixel_s'(fifo_head_raw);

    vgast_fifo #(
        .WIDTH(vgast_pkg::PIXEL_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_data_i(pix_data_i),
        .in_valid_i(pix_valid_i),
        .in_ready_o(fifo_ready),
        .out_data_o(fifo_head_raw),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop),
        .level_o(fifo_level_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Fetch address walks the visible raster in order, one per accepted word
    // Counts accepted words, not screen positions, so it leads the raster
    // by the buffer level and wraps after the last visible pixel
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fetch_addr_q <= '0;
        end else if (push) begin
            if (fetch_addr_q == ADDR_LAST) begin
                fetch_addr_q <= '0; // RULE9
            end else begin
                fetch_addr_q <= fetch_addr_q + 1'b1; // RULE12
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Colour register, blank outside the visible area or on a missing word
    // A waiting word never leaks into porch or pulse intervals,
    // so blanking holds even with a full buffer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rgb_q <= vgast_pkg::PIXEL_BLANK; // RULE15
        end else if (pop) begin
            rgb_q <= fifo_head; // RULE1 RULE11
        end else begin
            rgb_q <= vgast_pkg::PIXEL_BLANK; // RULE6
        end
    end

    // Horizontal sync register, delayed one clock to line up with the colour
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hsync_n_q <= vgast_pkg::SYNC_IDLE;
        end else begin
            hsync_n_q <= !h_pulse; // RULE14 RULE2
        end
    end

    // Vertical sync register, delayed likewise
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            vsync_n_q <= vgast_pkg::SYNC_IDLE;
        end else begin
            vsync_n_q <= !v_pulse; // RULE14 RULE2
        end
    end

    // Visible flag aligned with the colour
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            active_q <= 1'b0;
        end else begin
            active_q <= visible; // RULE6
        end
    end

    // Frame pulse on the first pixel of the raster
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            frame_start_q <= 1'b0;
        end else begin
            frame_start_q <= frame_origin; // RULE12
        end
    end

    // Starved pixel flag, no word for a visible position
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            underrun_q <= 1'b0;
        end else begin
            underrun_q <= visible && !fifo_valid; // RULE11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    // Column and row leave undelayed: they lead the colour by one clock,
    // the time a registered memory read needs
    assign rgb_o = rgb_q;
    assign hsync_n_o = hsync_n_q;
    assign vsync_n_o = vsync_n_q;
    assign active_o = active_q;
    assign frame_start_o = frame_start_q;
    assign underrun_o = underrun_q;
    assign fetch_addr_o = fetch_addr_q;
    assign col_o = hcount_q; // RULE7
    assign row_o = vcount_q; // RULE8

endmodule : vgast_timing

//--- tb/vgast_timing_sva.sv
// Checker of counter, sync, blanking and buffer relations at the controller ports
module vgast_timing_sva #(
    parameter int H_VISIBLE = vgast_pkg::H_VISIBLE,
    parameter int H_FRONT = vgast_pkg::H_FRONT,
    parameter int H_SYNC = vgast_pkg::H_SYNC,
    parameter int H_BACK = vgast_pkg::H_BACK,
    parameter int V_VISIBLE = vgast_pkg::V_VISIBLE,
    parameter int V_FRONT = vgast_pkg::V_FRONT,
    parameter int V_SYNC = vgast_pkg::V_SYNC,
    parameter int V_BACK = vgast_pkg::V_BACK,
    parameter int FIFO_DEPTH = vgast_pkg::FIFO_DEPTH,
    localparam int H_TOTAL = H_VISIBLE + H_FRONT + H_SYNC + H_BACK,
    localparam int V_TOTAL = V_VISIBLE + V_FRONT + V_SYNC + V_BACK,
    localparam int HCW = $clog2(H_TOTAL),
    localparam int VCW = $clog2(V_TOTAL),
    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1
) (
    input wire logic clk_i, // Clock
    input wire logic reset_i, // Reset
    input wire logic pix_ready_o, // Room
    input wire vgast_pkg::vgast_pixel_s rgb_o, // Colour
    input wire logic hsync_n_o, // Hsync
    input wire logic vsync_n_o, // Vsync
    input wire logic active_o, // Visible
    input wire logic frame_start_o, // Frame pulse
    input wire logic underrun_o, // Starved
    input wire logic [HCW-1:0] col_o, // Column
    input wire logic [VCW-1:0] row_o, // Row
    input wire logic [LVL_W-1:0] fifo_level_o // Level
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    ////////////////////////////////////////////////////////////////////////////
    // Counters and their decode, outputs one cycle behind the counters
    chk_reset_origin: assert property (
        $past(reset_i) |-> col_o == '0 && row_o == '0 && rgb_o == '0 && hsync_n_o && vsync_n_o)
        else $error("not at origin after reset");
    chk_col_wrap: assert property (
        !$past(reset_i) |-> col_o == ($past(col_o) == H_TOTAL - 1 ? '0 : $past(col_o) + 1'b1))
        else $error("column misstep");
    chk_row_step: assert property (
        !$past(reset_i) |-> row_o == (col_o != H_VISIBLE + H_FRONT ? $past(row_o)
            : $past(row_o) == V_TOTAL - 1 ? '0 : $past(row_o) + 1'b1))
        else $error("row misstep");
    chk_hsync_decode: assert property (
        !$past(reset_i) |-> hsync_n_o == !($past(col_o) >= H_VISIBLE + H_FRONT
            && $past(col_o) < H_VISIBLE + H_FRONT + H_SYNC))
        else $error("hsync misplaced");
    chk_vsync_decode: assert property (
        !$past(reset_i) |-> vsync_n_o == !($past(row_o) >= V_VISIBLE + V_FRONT
            && $past(row_o) < V_VISIBLE + V_FRONT + V_SYNC))
        else $error("vsync misplaced");
    chk_active_decode: assert property (
        !$past(reset_i) |-> active_o == ($past(col_o) < H_VISIBLE && $past(row_o) < V_VISIBLE))
        else $error("active misplaced");
    chk_frame_pulse: assert property (
        !$past(reset_i) |-> frame_start_o == ($past(col_o) == '0 && $past(row_o) == '0))
        else $error("frame pulse misplaced");

    ////////////////////////////////////////////////////////////////////////////
    // Colour blanking and buffer status
    chk_blank_outside: assert property (!active_o |-> rgb_o == '0)
        else $error("colour outside visible area");
    chk_underrun_blank: assert property (underrun_o |-> active_o && rgb_o == '0)
        else $error("starved pixel not blank");
    chk_ready_full: assert property (pix_ready_o == (fifo_level_o != FIFO_DEPTH))
        else $error("ready disagrees with level");
    cov_frame: cover property (frame_start_o);
    cov_starve: cover property (underrun_o);
    cov_full: cover property (!pix_ready_o);
endmodule : vgast_timing_sva

bind vgast_timing vgast_timing_sva #(.H_VISIBLE(H_VISIBLE), .H_FRONT(H_FRONT), .H_SYNC(H_SYNC),
    .H_BACK(H_BACK), .V_VISIBLE(V_VISIBLE), .V_FRONT(V_FRONT), .V_SYNC(V_SYNC),
    .V_BACK(V_BACK), .FIFO_DEPTH(FIFO_DEPTH)) vgast_timing_sva_i (.clk_i(clk_i),
    .reset_i(reset_i), .pix_ready_o(pix_ready_o), .rgb_o(rgb_o), .hsync_n_o(hsync_n_o),
    .vsync_n_o(vsync_n_o), .active_o(active_o), .frame_start_o(frame_start_o),
    .underrun_o(underrun_o), .col_o(col_o), .row_o(row_o), .fifo_level_o(fifo_level_o));

//--- tb/vgast_monitor_model.sv
// Behavioural display model that measures sync pulses and periods
module vgast_monitor_model (
    input wire logic clk_i, // Pixel clock
    input wire vgast_pkg::vgast_pixel_s rgb_i, // Colour lines
    input wire logic hsync_n_i, // Horizontal sync
    input wire logic vsync_n_i // Vertical sync
);
    timeunit 1ns;
    timeprecision 1ns;
    int hs_low = 0, vs_low = 0, line_len = 0, frame_len = 0, ln = 0, fr = 0, lit = 0;

    // Pulse widths, periods and colour seen while a sync is low
    always @(posedge clk_i) begin
        ln = ln + 1;
        fr = fr + 1;
        if (!hsync_n_i) hs_low = $fell(hsync_n_i) ? 1 : hs_low + 1;
        if (!vsync_n_i) vs_low = $fell(vsync_n_i) ? 1 : vs_low + 1;
        if ((!hsync_n_i || !vsync_n_i) && rgb_i != '0) lit = lit + 1;
        if ($fell(hsync_n_i)) begin
            line_len = ln;
            ln = 0;
        end
        if ($fell(vsync_n_i)) begin
            frame_len = fr;
            fr = 0;
        end
    end
endmodule : vgast_monitor_model

//--- tb/tb_top.sv
// Self-checking bench for the raster controller in a shortened mode
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HV = 8, HF = 2, HS = 2, HB = 2, VV = 4, VF = 1, VS = 1, VB = 1;
    localparam int HT = HV + HF + HS + HB, VT = VV + VF + VS + VB, NPIX = HV * VV;
    localparam int CLK = 60 * HT * VT;
    logic clk_i = 0, reset_i = 1, pix_valid_i = 1;
    logic pix_ready_o, hsync_n_o, vsync_n_o, active_o, frame_start_o, underrun_o;
    logic [4:0] fetch_addr_o;
    logic [3:0] col_o;
    logic [2:0] row_o;
    logic [5:0] fifo_level_o;
    vgast_pkg::vgast_pixel_s pix_data_i = 12'h5a3, rgb_o;
    int src = 0, nxt = 0, exp_idx = 0, n_under = 0, u = 0, n_fail = 0, num_checks = 0;
    // Raster points: column, row, expected {hsync_n, vsync_n, active, frame_start}
    int tbl [11][3] = '{'{0, 0, 4'hf}, '{7, 0, 4'he}, '{8, 0, 4'hc}, '{10, 0, 4'h4},
        '{11, 0, 4'h4}, '{12, 0, 4'hc}, '{3, 3, 4'he}, '{3, 4, 4'hc}, '{9, 5, 4'h8},
        '{10, 5, 4'h0}, '{10, 6, 4'h4}};

    vgast_timing #(.CLK_HZ(CLK), .H_VISIBLE(HV), .H_FRONT(HF), .H_SYNC(HS), .H_BACK(HB),
        .V_VISIBLE(VV), .V_FRONT(VF), .V_SYNC(VS), .V_BACK(VB)) vgast_timing_i (
        .clk_i(clk_i), .reset_i(reset_i), .pix_data_i(pix_data_i), .pix_valid_i(pix_valid_i),
        .pix_ready_o(pix_ready_o), .fetch_addr_o(fetch_addr_o), .rgb_o(rgb_o),
        .hsync_n_o(hsync_n_o), .vsync_n_o(vsync_n_o), .active_o(active_o),
        .frame_start_o(frame_start_o), .underrun_o(underrun_o), .col_o(col_o), .row_o(row_o),
        .fifo_level_o(fifo_level_o));
    vgast_monitor_model vgast_monitor_model_i (.clk_i(clk_i), .rgb_i(rgb_o),
        .hsync_n_i(hsync_n_o), .vsync_n_i(vsync_n_o));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and shared tasks
    initial begin
        forever #20 clk_i = ~clk_i;
    end

    function automatic vgast_pkg::vgast_pixel_s pat(input int a);
        pat = 12'(a) * 12'h0a7 ^ 12'h5a3;
    endfunction : pat

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected %s: expected %0h, seen %0h", what, want, seen);
        end
    endtask : check

    task automatic wait_at(input int c, input int r);
        int k;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while ((col_o !== c || row_o !== r) && k < 300);
        check("reach", k < 300, 1);
    endtask : wait_at

    task automatic release_chk();
        reset_i <= 0;
        repeat (2) @(posedge clk_i);
        check("col", col_o, 1);
        check("origin", {frame_start_o, active_o, underrun_o, hsync_n_o, vsync_n_o}, 5'h1f);
    endtask : release_chk

    task automatic results();
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////
    // Raster-order word source, one word per take
    always @(posedge clk_i) begin
        if (reset_i) nxt = 0;
        else nxt = (pix_valid_i && pix_ready_o) ? (src + 1) % NPIX : src;
        src <= nxt;
        pix_data_i <= pat(nxt);
    end

    // Colour scoreboard; a starved pixel is blank and consumes no word
    always @(posedge clk_i) begin
        if (reset_i) exp_idx = 0;
        else if (active_o && underrun_o) n_under++;
        else if (active_o) begin
            check("rgb", rgb_o, pat(exp_idx));
            exp_idx = (exp_idx + 1) % NPIX;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        release_chk();
        foreach (tbl[i]) begin
            wait_at(tbl[i][0], tbl[i][1]);
            @(posedge clk_i);
            check("raster", {hsync_n_o, vsync_n_o, active_o, frame_start_o}, tbl[i][2]);
        end
        repeat (3 * HT * VT) @(posedge clk_i);
        check("hs_low", vgast_monitor_model_i.hs_low, HS);
        check("line", vgast_monitor_model_i.line_len, HT);
        check("vs_low", vgast_monitor_model_i.vs_low, VS * HT);
        check("frame", vgast_monitor_model_i.frame_len, HT * VT);
        check("rate", CLK / vgast_monitor_model_i.frame_len, 60);
        check("lit", vgast_monitor_model_i.lit, 0);
        wait_at(HT - 1, VT - 1);
        check("full", {pix_ready_o, fifo_level_o}, 7'h20);
        check("addr", fetch_addr_o, src);
        pix_valid_i <= 0;
        u = n_under;
        repeat (2 * HT * VT) @(posedge clk_i);
        check("starved", n_under - u, NPIX);
        check("empty", fifo_level_o, 0);
        pix_valid_i <= 1;
        wait_at(5, 2);
        reset_i <= 1;
        @(posedge clk_i);
        release_chk();
        repeat (2 * HT * VT) @(posedge clk_i);
        results();
    end

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        results();
    end
endmodule : tb_top
